// file: shared/psie_cfg.svh
// Register indices, reset values and write masks of the status and interrupt-enable bank.
`ifndef PSIE_CFG_SVH
`define PSIE_CFG_SVH

// ==========================================================================
// Bus geometry
`define PSIE_ADDR_W 12
`define PSIE_ADDR(idx) ({2'h0, (idx), 2'h0})

// ==========================================================================
// Register indices; the byte address is four times the index
`define PSIE_IDX_STATUS 8'h11
`define PSIE_IDX_IRQEN 8'h12
`define PSIE_IDX_EVENT 8'h13
`define PSIE_IDX_CFG 8'h14

// ==========================================================================
// Reset values and writable-bit masks
`define PSIE_IRQEN_RST 16'h0000
`define PSIE_IRQEN_WMASK 16'hfd7f
`define PSIE_CFG_RST 16'h2000
`define PSIE_CFG_WMASK 16'h2000
`define PSIE_EVENT_RST 16'h0000

// ==========================================================================
// Codes
`define PSIE_RATE_10 2'h0
`define PSIE_RATE_GIG 2'h2
`define PSIE_POL10_RST 1'h1

`endif

// file: shared/psie_pkg.sv
// Types shared by the status and interrupt-enable bank.
package psie_pkg;

  // Live line state from the transceiver core, sampled every enabled cycle.
  typedef struct packed {
    logic [1:0] resolved_rate;
    logic full_duplex;
    logic neg_resolved;
    logic link_up;
    logic crossover_pairs_cd;
    logic crossover_pairs_ab;
    logic downshift_active;
    logic sleeping;
    logic [3:0] channel_polarity_flags;
    logic pol10_ok;
    logic jabber;
  } psie_line_t;

  // One-cycle event pulses that cannot be derived from the line state.
  typedef struct packed {
    logic neg_fault;
    logic page_rx;
    logic false_carrier;
    logic downshift_event;
    logic wake_packet;
    logic xgmii_err;
  } psie_pulse_t;

  // Layout of the status summary word, bit 15 first.
  typedef struct packed {
    logic [1:0] resolved_rate;
    logic full_duplex;
    logic page_rx;
    logic neg_resolved;
    logic link_up;
    logic crossover_pairs_cd;
    logic crossover_pairs_ab;
    logic downshift_active;
    logic sleeping;
    logic [3:0] channel_polarity_flags;
    logic pol10_ok;
    logic jabber;
  } psie_sts_t;

  // Layout shared by the event flag word and the enable word, bit 15 first.
  typedef struct packed {
    logic neg_fault;
    logic rate_change;
    logic duplex_change;
    logic page_rx;
    logic neg_done;
    logic link_change;
    logic rsvd9;
    logic false_carrier;
    logic rsvd7;
    logic crossover_change;
    logic downshift_event;
    logic sleep_change;
    logic wake_packet;
    logic xgmii_err;
    logic polarity_change;
    logic jabber;
  } psie_evt_t;

endpackage : psie_pkg

// file: design/psie_regs.sv
// Status summary, event flags, interrupt enables and interrupt pin behind an APB slave.
//
// Summary of operation
// - Bits 15:14 report speed: 00 10M, 01 100M, 10 1000M, 11 reserved.
// - Bit 13 reads 1 for full duplex, 0 for half duplex.
// - Bit 12 latches on a received page and clears when the status word is read.
// - Bit 11 is 1 when negotiation finished or disabled, else 0.
// - Bit 10 shows the present link state, 1 meaning up.
// - Bit 9 gives C/D pair crossover, bit 8 A/B pairs, 1 meaning crossed.
// - Bit 7 is set while negotiating with gigabit abilities masked by downshift.
// - Bit 6 reads 1 while sleeping, 0 while active.
// - Bits 5:2 give polarity of channels D,C,B,A at gigabit link, 1 reversed.
// - Bit 1 gives 10M receive polarity, 1 correct, resetting to 1.
// - Bit 0 copies the jabber flag; reading the status word never clears it.
// - An event raises the interrupt only while its enable bit is set.
// - Enable bits 15..12: negotiation fault, rate, duplex, page; reset 0.
// - Enable bits 11 and 10: negotiation done, link change; reset 0.
// - Enable bit 8 false carrier, bit 6 crossover; bits 9 and 7 read 0.
// - Enable bits 5, 4, 3: downshift event, sleep change, wake packet; reset 0.
// - Event flags set regardless of enables and clear when the flag word is read.
// - Interrupt pin is active low by default; clearing the polarity bit makes it high.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "psie_cfg.svh"

module psie_regs (
  // Clock, reset and clock enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PSIE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transceiver core
  input wire psie_pkg::psie_line_t line_in,
  input wire psie_pkg::psie_pulse_t pulse_in,
  // Interrupt
  output logic irq,
  output logic irq_pin
);
  import psie_pkg::*;

  // ==========================================================================
  // Registers
  // Every flop below holds its value while the clock enable is low. The only
  // exception is the read data and error capture, which follows the bus and not the core.
  psie_line_t line_q;
  logic page_q;
  logic page_d;
  psie_evt_t ev_q;
  psie_evt_t ev_d;
  logic [15:0] en_q;
  logic [15:0] en_d;
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [31:0] rdata_q;
  logic err_q;

  // ==========================================================================
  // APB decode
  // The slave answers with no wait state, but a low clock enable stretches the
  // access phase so that no side effect is lost while state is frozen.
  // The setup cycle captures read data whatever the clock enable does. A master
  // may present its setup while the core is frozen and move on to the access
  // phase at once; gating the capture would then hand it stale data.
  // Capturing a frozen register is harmless, since it cannot change until the
  // enable returns, and all side effects still wait for the enabled access edge.
  // Write effects and read clears happen only at the access edge, never in setup.
  wire setup = psel & ~penable;
  wire done = psel & penable & clk_en;
  wire hit_sts = paddr == `PSIE_ADDR(`PSIE_IDX_STATUS);
  wire hit_en = paddr == `PSIE_ADDR(`PSIE_IDX_IRQEN);
  wire hit_ev = paddr == `PSIE_ADDR(`PSIE_IDX_EVENT);
  wire hit_cfg = paddr == `PSIE_ADDR(`PSIE_IDX_CFG);
  wire hit_any = hit_sts | hit_en | hit_ev | hit_cfg;
  wire rd_sts = done & ~pwrite & hit_sts;
  wire rd_ev = done & ~pwrite & hit_ev;
  wire wr_en = done & pwrite & hit_en;
  wire wr_ev = done & pwrite & hit_ev;
  wire wr_cfg = done & pwrite & hit_cfg;
  wire [15:0] bmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] wdat = pwdata[15:0];

  assign pready = clk_en;
  assign pslverr = err_q & penable;
  assign prdata = rdata_q;

  // ==========================================================================
  // Status summary word, built from the registered line snapshot.
  // Channel polarity only means something at a gigabit link, so it is masked
  // to normal otherwise rather than showing stale core state.
  // All other fields but the page latch pass straight through from the snapshot. The downshift
  // and jabber bits only mean something in certain modes, but they are shown
  // as the core reports them; software has to judge their meaning itself.
  // Reading this word never touches the jabber copy; only the page bit clears.
  wire gig_link = line_q.link_up & (line_q.resolved_rate == `PSIE_RATE_GIG);
  psie_sts_t sts;
  assign sts.resolved_rate = line_q.resolved_rate;
  assign sts.full_duplex = line_q.full_duplex;
  assign sts.page_rx = page_q;
  assign sts.neg_resolved = line_q.neg_resolved;
  assign sts.link_up = line_q.link_up;
  assign sts.crossover_pairs_cd = line_q.crossover_pairs_cd;
  assign sts.crossover_pairs_ab = line_q.crossover_pairs_ab;
  assign sts.downshift_active = line_q.downshift_active;
  assign sts.sleeping = line_q.sleeping;
  assign sts.channel_polarity_flags = gig_link ? line_q.channel_polarity_flags : 4'h0;
  assign sts.pol10_ok = line_q.pol10_ok;
  assign sts.jabber = line_q.jabber;

  // ==========================================================================
  // Event detection: changes are seen against the previous snapshot, so a
  // flag rises in the same cycle that the new state reaches the status word.
  // Level changes of rate, duplex, link, crossover and sleep count both ways;
  // negotiation done and jabber count only on their rising edge.
  // Pulse inputs must last one enabled cycle; a pulse that arrives while the
  // clock enable is low is lost, which the core has to respect.
  psie_evt_t ev_set;
  assign ev_set.neg_fault = pulse_in.neg_fault;
  assign ev_set.rate_change = line_in.resolved_rate != line_q.resolved_rate;
  assign ev_set.duplex_change = line_in.full_duplex != line_q.full_duplex;
  assign ev_set.page_rx = pulse_in.page_rx;
  assign ev_set.neg_done = line_in.neg_resolved & ~line_q.neg_resolved;
  assign ev_set.link_change = line_in.link_up != line_q.link_up;
  assign ev_set.rsvd9 = 1'h0;
  assign ev_set.false_carrier = pulse_in.false_carrier;
  assign ev_set.rsvd7 = 1'h0;
  assign ev_set.crossover_change = {line_in.crossover_pairs_cd, line_in.crossover_pairs_ab}
                                   != {line_q.crossover_pairs_cd, line_q.crossover_pairs_ab};
  assign ev_set.downshift_event = pulse_in.downshift_event;
  assign ev_set.sleep_change = line_in.sleeping != line_q.sleeping;
  assign ev_set.wake_packet = pulse_in.wake_packet;
  assign ev_set.xgmii_err = pulse_in.xgmii_err;
  assign ev_set.polarity_change = {line_in.channel_polarity_flags, line_in.pol10_ok}
                                  != {line_q.channel_polarity_flags, line_q.pol10_ok};
  assign ev_set.jabber = line_in.jabber & ~line_q.jabber;

  // ==========================================================================
  // Next values. Flags set by hardware win over a clear in the same cycle.
  // The flag word clears on read and also accepts write-one-to-clear.
  // An event in the very cycle of a clearing read survives it, but one that lands
  // at the setup edge is missing from the captured data and then cleared, so software can miss it.
  // Reserved enable bits are kept at zero by the write mask, not by the flop.
  // Byte strobes gate each half of a write independently.
  wire [15:0] ev_clr = rd_ev ? 16'hffff : (wr_ev ? (wdat & bmask) : 16'h0000);
  assign ev_d = (ev_q & ~ev_clr) | ev_set;
  assign page_d = pulse_in.page_rx | (page_q & ~rd_sts);
  wire [15:0] en_wm = `PSIE_IRQEN_WMASK & bmask;
  assign en_d = wr_en ? ((en_q & ~en_wm) | (wdat & en_wm)) : en_q;
  wire [15:0] cfg_wm = `PSIE_CFG_WMASK & bmask;
  assign cfg_d = wr_cfg ? ((cfg_q & ~cfg_wm) | (wdat & cfg_wm)) : cfg_q;

  // Read mux for the setup phase; data is held in a flop for the access phase.
  wire [15:0] rd_mux = hit_sts ? sts :
                       hit_en ? en_q :
                       hit_ev ? ev_q :
                       hit_cfg ? cfg_q : 16'h0000;

  // ==========================================================================
  // Interrupt: level while any enabled flag is pending; the pin polarity bit
  // resets to active low. Reading the flag word drops it on the next edge.
  // The enable is applied to the pending flag, not to the event itself, so
  // enabling a source with a flag already pending raises the line at once.
  // The pin is a plain push-pull output here; any open-drain wiring and its
  // pull-up sit outside this block.
  psie_evt_t en_view;
  assign en_view = en_q;
  wire pend = |(ev_q & en_view);
  wire pol_low = cfg_q[13];
  assign irq = pend;
  assign irq_pin = pol_low ? ~pend : pend;

  // ==========================================================================
  // Line snapshot; the 10M polarity bit resets to correct.
  // The core's line state is taken as synchronous to this clock.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_q <= '0;
      line_q.pol10_ok <= `PSIE_POL10_RST;
    end else if (clk_en) begin
      line_q <= line_in;
    end
  end

  // Page latch and event flags.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_q <= 1'h0;
      ev_q <= `PSIE_EVENT_RST;
    end else if (clk_en) begin
      page_q <= page_d;
      ev_q <= ev_d;
    end
  end

  // Enable and configuration words.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= `PSIE_IRQEN_RST;
      cfg_q <= `PSIE_CFG_RST;
    end else if (clk_en) begin
      en_q <= en_d;
      cfg_q <= cfg_d;
    end
  end

  // Read data and error, captured in the setup cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'h0;
    end else if (setup) begin
      rdata_q <= pwrite ? 32'h0000_0000 : {16'h0000, rd_mux};
      err_q <= ~hit_any;
    end
  end

  // ==========================================================================
  // Checks
  // Properties watch the design's own state, inputs and outputs. Reset disables all but the 10M polarity reset check,
  // and the read checks start from the setup cycle in which data is captured.
  // Events in the very cycle of a clearing access are excluded where a check
  // would otherwise fire on the set-wins behaviour.
  sequence seq_sts_setup;
    setup && !pwrite && hit_sts;
  endsequence

  sequence seq_sts_read;
    rd_sts && !pulse_in.page_rx;
  endsequence

  sequence seq_en_cleared;
    wr_en && bmask == 16'hffff && wdat == 16'h0000;
  endsequence

  sequence seq_ev_read;
    rd_ev && ev_set == 16'h0000;
  endsequence

  chk_speed_read: assert property (@(posedge clk) disable iff (!rst_b)
    (setup && !pwrite && hit_sts) |=> prdata[15:14] == $past(line_q.resolved_rate))
    else $error("speed field read back wrong");

  chk_page_latch: assert property (@(posedge clk) disable iff (!rst_b)
    (clk_en && pulse_in.page_rx) |=> page_q ##1 (page_q || $past(rd_sts)))
    else $error("page flag not latched");

  chk_page_clear: assert property (@(posedge clk) disable iff (!rst_b)
    seq_sts_read |=> !page_q)
    else $error("page flag not cleared by status read");

  chk_chanpol_gate: assert property (@(posedge clk) disable iff (!rst_b)
    sts.channel_polarity_flags != 4'h0 |-> sts.link_up && sts.resolved_rate == `PSIE_RATE_GIG)
    else $error("channel polarity shown without gigabit link");

  chk_pol10_reset: assert property (@(posedge clk)
    $rose(rst_b) |-> sts.pol10_ok)
    else $error("10M polarity not reset to correct");

  chk_jabber_keep: assert property (@(posedge clk) disable iff (!rst_b)
    (rd_sts && line_in.jabber) |=> sts.jabber)
    else $error("jabber copy cleared by status read");

  chk_en_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    seq_en_cleared |=> !irq [*2])
    else $error("interrupt with all enables cleared");

  chk_en_reserved: assert property (@(posedge clk) disable iff (!rst_b)
    en_view.rsvd9 == 1'h0 && en_view.rsvd7 == 1'h0)
    else $error("reserved enable bit set");

  chk_ev_set: assert property (@(posedge clk) disable iff (!rst_b)
    (clk_en && ev_set != 16'h0000) |=> (ev_q & $past(ev_set)) == $past(ev_set))
    else $error("event flag lost");

  chk_ev_cor: assert property (@(posedge clk) disable iff (!rst_b)
    seq_ev_read |=> ev_q == 16'h0000)
    else $error("flag word not cleared by read");

  chk_pin_level: assert property (@(posedge clk) disable iff (!rst_b)
    (rd_ev && ev_set == 16'h0000 && cfg_q[13]) |=> irq_pin)
    else $error("active-low pin not released after clearing read");

  chk_irq_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (irq && !rd_ev && !wr_ev && !wr_en) |=> irq)
    else $error("interrupt dropped while enabled flag pending");

  // Each status field other than page and channel polarity, read in a setup cycle, shows the snapshot of that cycle.
  chk_duplex_read: assert property (@(posedge clk) disable iff (!rst_b)
    seq_sts_setup |=> prdata[13] == $past(line_q.full_duplex))
    else $error("duplex bit read back wrong");

  // Negotiation resolved bit.
  chk_resolved_read: assert property (@(posedge clk) disable iff (!rst_b)
    seq_sts_setup |=> prdata[11] == $past(line_q.neg_resolved))
    else $error("resolved bit read back wrong");

  // Link state bit.
  chk_link_read: assert property (@(posedge clk) disable iff (!rst_b)
    seq_sts_setup |=> prdata[10] == $past(line_q.link_up))
    else $error("link bit read back wrong");

  // Crossover bits, C/D pairs above A/B pairs.
  chk_cross_read: assert property (@(posedge clk) disable iff (!rst_b)
    seq_sts_setup |=> prdata[9:8] == $past({line_q.crossover_pairs_cd,
                                            line_q.crossover_pairs_ab}))
    else $error("crossover bits read back wrong");

  // Downshift status bit.
  chk_downshift_read: assert property (@(posedge clk) disable iff (!rst_b)
    seq_sts_setup |=> prdata[7] == $past(line_q.downshift_active))
    else $error("downshift bit read back wrong");

  // Sleep state bit.
  chk_sleep_read: assert property (@(posedge clk) disable iff (!rst_b)
    seq_sts_setup |=> prdata[6] == $past(line_q.sleeping))
    else $error("sleep bit read back wrong");

  // 10M polarity bit.
  chk_pol10_read: assert property (@(posedge clk) disable iff (!rst_b)
    seq_sts_setup |=> prdata[1] == $past(line_q.pol10_ok))
    else $error("10M polarity bit read back wrong");

  // Jabber copy bit.
  chk_jabber_read: assert property (@(posedge clk) disable iff (!rst_b)
    seq_sts_setup |=> prdata[0] == $past(line_q.jabber))
    else $error("jabber bit read back wrong");

  // A full-word enable write keeps exactly the writable bits.
  chk_en_write: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_en && bmask == 16'hffff) |=> en_q == ($past(wdat) & `PSIE_IRQEN_WMASK))
    else $error("enable write landed wrong");

  // Enables change only by a write.
  chk_en_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !wr_en |=> $stable(en_q))
    else $error("enable word changed without a write");

  // No enable, no interrupt, whatever is pending.
  chk_irq_masked: assert property (@(posedge clk) disable iff (!rst_b)
    en_q == 16'h0000 |-> !irq)
    else $error("interrupt raised with no enable set");

  // Active-high setting makes the pin follow the level.
  chk_pin_follow: assert property (@(posedge clk) disable iff (!rst_b)
    !cfg_q[13] |-> irq_pin == irq)
    else $error("active-high pin does not follow interrupt");

  // A low clock enable freezes the flags and the page latch.
  chk_flags_frozen: assert property (@(posedge clk) disable iff (!rst_b)
    !clk_en |=> $stable(ev_q) && $stable(page_q))
    else $error("flag state moved while clock enable low");

  // Reserved flag positions never set.
  chk_ev_reserved: assert property (@(posedge clk) disable iff (!rst_b)
    ev_q.rsvd9 == 1'h0 && ev_q.rsvd7 == 1'h0)
    else $error("reserved flag bit set");

endmodule : psie_regs
`default_nettype wire

// file: tb/psie_core_model.sv
// Behavioural transceiver core that feeds line state and event pulses to the bank.
`timescale 1ns/1ps
`default_nettype none

module psie_core_model (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire psie_pkg::psie_line_t line_cmd,
  input wire psie_pkg::psie_pulse_t fire,
  // Towards the bank
  output var psie_pkg::psie_line_t line_in,
  output var psie_pkg::psie_pulse_t pulse_in
);
  import psie_pkg::*;

  // ==========================================================================
  // Core outputs
  // Registered, as the real core is, so every change lands just after an edge.
  always_ff @(posedge clk) begin
    line_in <= line_cmd;
    pulse_in <= fire;
  end
endmodule : psie_core_model

`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the status summary and interrupt-enable bank.
`timescale 1ns/1ps
`default_nettype none
`include "psie_cfg.svh"

module testbench;
  import psie_pkg::*;

  logic clk, rst_b, clk_en, psel, penable, pwrite, pready, pslverr, irq, irq_pin, err;
  logic [`PSIE_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  psie_line_t line_cmd, line_in;
  psie_pulse_t fire, pulse_in;
  int n_mismatch = 0;
  int tests_run = 0;
  int page = 0;
  int unsigned seed = 90065;
  // Flag position of each pulse input, pulse bit 0 first.
  int flag_bit[6] = '{2, 3, 5, 8, 12, 15};

  psie_regs u_psie_regs (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
    .pulse_in(pulse_in), .irq(irq), .irq_pin(irq_pin));
  psie_core_model u_psie_core_model (.clk(clk), .line_cmd(line_cmd), .fire(fire),
    .line_in(line_in), .pulse_in(pulse_in));

  // ==========================================================================
  // Helpers
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected status word; channel polarity only counts at a gigabit link.
  function automatic logic [15:0] exp_sts(psie_line_t l);
    return {l.resolved_rate, l.full_duplex, page[0], l.neg_resolved, l.link_up,
      l.crossover_pairs_cd, l.crossover_pairs_ab, l.downshift_active, l.sleeping,
      (l.link_up && l.resolved_rate == 2'h2) ? l.channel_polarity_flags : 4'h0,
      l.pol10_ok, l.jabber};
  endfunction : exp_sts

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= `PSIE_ADDR(idx);
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // A one-cycle event pulse from the core, then time for the flag to land.
  task automatic pulse(input int j);
    fire <= psie_pulse_t'(6'(1 << j));
    @(posedge clk);
    fire <= '0;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // The sequence needs well under a thousand cycles; ten thousand means a hang.
  initial begin
    #40000;
    n_mismatch++;
    wrap_up();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, fire} = '0;
    clk_en = 1'b1;
    line_cmd = '0;
    line_cmd.pol10_ok = 1'b1;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    chk("pin idle", 1, irq_pin);
    @(posedge clk);
    apb(0, `PSIE_IDX_STATUS, 0);
    chk("status reset", 16'h0002, rd);
    apb(0, `PSIE_IDX_IRQEN, 0);
    chk("enable reset", 0, rd);
    apb(0, `PSIE_IDX_CFG, 0);
    chk("cfg reset", 16'h2000, rd);
    apb(1, `PSIE_IDX_IRQEN, 32'hffff);
    apb(0, `PSIE_IDX_IRQEN, 0);
    chk("enable mask", 16'hfd7f, rd);
    // A low clock enable stalls the access phase; the write lands once it returns.
    fork
      apb(1, `PSIE_IDX_IRQEN, 32'h0400);
      begin
        @(posedge clk);
        clk_en <= 1'b0;
        @(posedge clk);
        chk("ready stalled", 0, pready);
        repeat (2) @(posedge clk);
        clk_en <= 1'b1;
      end
    join
    apb(0, `PSIE_IDX_IRQEN, 0);
    chk("enable stalled write", 16'h0400, rd);
    apb(1, `PSIE_IDX_STATUS, 32'hffff);
    // Random line states, with pages now and then; a read must clear the page bit.
    repeat (60) begin
      line_cmd <= psie_line_t'(15'(rnd()));
      if (rnd() % 3 == 0) begin
        pulse(4);
        page = 1;
      end
      repeat (3) @(posedge clk);
      apb(0, `PSIE_IDX_STATUS, 0);
      chk("status word", exp_sts(line_cmd), rd);
      page = 0;
    end
    // Each pulse event: masked, then enabled, then cleared by reading the flags.
    for (int j = 0; j < 6; j++) begin
      apb(1, `PSIE_IDX_IRQEN, 0);
      apb(0, `PSIE_IDX_EVENT, 0);
      pulse(j);
      chk("irq masked", 0, irq);
      apb(0, `PSIE_IDX_EVENT, 0);
      chk("flag word", 32'h1 << flag_bit[j], rd);
      apb(1, `PSIE_IDX_IRQEN, 32'h1 << flag_bit[j]);
      pulse(j);
      chk("irq raised", 1, irq);
      chk("pin low", 0, irq_pin);
      apb(0, `PSIE_IDX_EVENT, 0);
      chk("irq released", 0, irq);
    end
    apb(1, `PSIE_IDX_CFG, 0);
    pulse(5);
    chk("pin high", 1, irq_pin);
    apb(0, 8'h3c, 0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
